// file: design/register_bit_attribute_cells.sv
`timescale 1ns/1ps
`include "bit_cells_cfg.svh"
module register_bit_attribute_cells (
  input  wire logic        sys_clk_i,             // 250 MHz system clock
  input  wire logic        rstn_i,                // hardware reset, sync, active low
  input  wire logic        sw_rst_i,              // software reset request
  input  wire logic        acc_rd_i,              // read access taken this cycle
  input  wire logic        acc_wr_i,              // write access taken this cycle
  input  wire logic [15:0] acc_wdata_i,           // write data
  output logic      [15:0] acc_rdata_o,           // read data, one cycle after acc_rd_i
  input  wire logic        ro_val_i,              // hardware value of read-only bit
  input  wire logic        wc_set_i,              // event for write-one-to-clear flag
  input  wire logic        write_any_clear_set_i, // event for write_any_clear flag
  input  wire logic        rc_set_i,              // event for read-to-clear flag
  input  wire logic        latch_low_cond_i,      // level watched by latch-low bit
  input  wire logic        latch_high_set_i,      // event for latch-high bit
  input  wire logic        sticky_cond_i,         // level watched by sticky_high_status
  output logic             wo_o,                  // write-only control bit
  output logic             self_clearing_o,       // self_clearing bit, one-cycle pulse
  output logic             ss_o,                  // self-setting bit
  output logic             rw_o,                  // plain read-write bit
  output logic             imm_o                  // soft_reset_immune read-write bit
);

  // ----------------------------------------------------------------
  // assertion clocking
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // set wins over clear so a coincident event is never dropped
  function automatic logic flag_next(input logic cur, input logic set, input logic clr);
    return set | (cur & ~clr);
  endfunction

  bit_cells_pkg::cells_state_t st_r;
  bit_cells_pkg::cells_state_t st_nxt;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // read data sampled before any clear-on-read takes effect;
    // write-only and reserved positions are left at zero
    st_nxt.rdata = 16'h0000;
    if (acc_rd_i) begin
      st_nxt.rdata[`RB_RO_BIT]       = ro_val_i;
      st_nxt.rdata[`RB_WC_BIT]       = st_r.wc;
      st_nxt.rdata[`RB_WR_ANY_BIT]   = st_r.write_any_clear;
      st_nxt.rdata[`RB_RC_BIT]       = st_r.rc;
      st_nxt.rdata[`RB_LATCH_LO_BIT] = st_r.latch_low;
      st_nxt.rdata[`RB_LATCH_HI_BIT] = st_r.latch_high;
      st_nxt.rdata[`RB_SELF_CLR_BIT] = st_r.self_clearing;
      st_nxt.rdata[`RB_SS_BIT]       = st_r.ss;
      st_nxt.rdata[`RB_STICKY_BIT]   = st_r.sticky;
      st_nxt.rdata[`RB_RW_BIT]       = st_r.rw;
      st_nxt.rdata[`RB_IMM_BIT]      = st_r.imm;
    end

    if (acc_wr_i) begin
      st_nxt.wo  = acc_wdata_i[`RB_WO_BIT];
      st_nxt.rw  = acc_wdata_i[`RB_RW_BIT];
      st_nxt.imm = acc_wdata_i[`RB_IMM_BIT];
    end

    st_nxt.wc = flag_next(st_r.wc, wc_set_i, acc_wr_i & acc_wdata_i[`RB_WC_BIT]);
    st_nxt.write_any_clear = flag_next(st_r.write_any_clear, write_any_clear_set_i,
                                       acc_wr_i);
    st_nxt.rc = flag_next(st_r.rc, rc_set_i, acc_rd_i);
    st_nxt.latch_high = flag_next(st_r.latch_high, latch_high_set_i, acc_rd_i);

    // latch-low: a low level wins, a read re-arms to one
    if (!latch_low_cond_i)
      st_nxt.latch_low = 1'h0;
    else if (acc_rd_i)
      st_nxt.latch_low = 1'h1;

    // sticky: after a read it simply follows the condition
    st_nxt.sticky = flag_next(st_r.sticky, sticky_cond_i, acc_rd_i);

    // self-clearing holds one cycle; self-setting is low one cycle
    st_nxt.self_clearing = acc_wr_i & acc_wdata_i[`RB_SELF_CLR_BIT];
    st_nxt.ss = ~(acc_wr_i & ~acc_wdata_i[`RB_SS_BIT]);

    if (sw_rst_i) begin
      // imm is left alone: it only falls to the hardware reset
      st_nxt.wo              = 1'h0;
      st_nxt.wc              = 1'h0;
      st_nxt.write_any_clear = 1'h0;
      st_nxt.rc              = 1'h0;
      st_nxt.latch_low       = `RB_LATCH_LO_RST;
      st_nxt.latch_high      = 1'h0;
      st_nxt.self_clearing   = 1'h0;
      st_nxt.ss              = `RB_SS_RST;
      st_nxt.sticky          = 1'h0;
      st_nxt.rw              = `RB_RW_RST;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      st_r           <= '0;
      st_r.latch_low <= `RB_LATCH_LO_RST;
      st_r.ss        <= `RB_SS_RST;
      st_r.rw        <= `RB_RW_RST;
      st_r.imm       <= `RB_IMM_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign acc_rdata_o     = st_r.rdata;
  assign wo_o            = st_r.wo;
  assign self_clearing_o = st_r.self_clearing;
  assign ss_o            = st_r.ss;
  assign rw_o            = st_r.rw;
  assign imm_o           = st_r.imm;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_ro_read;
    acc_rd_i |=> acc_rdata_o[`RB_RO_BIT] == $past(ro_val_i);
  endproperty
  a_ro_read: assert property (p_ro_read) else $error("read-only bit wrong");

  property p_wo_store;
    acc_wr_i && !sw_rst_i |=> wo_o == $past(acc_wdata_i[`RB_WO_BIT]);
  endproperty
  a_wo_store: assert property (p_wo_store) else $error("write-only not stored");

  property p_wc_clear;
    acc_wr_i && acc_wdata_i[`RB_WC_BIT] && !wc_set_i |=> !st_r.wc;
  endproperty
  a_wc_clear: assert property (p_wc_clear) else $error("wc not cleared");

  property p_wc_keep;
    st_r.wc && !(acc_wr_i && acc_wdata_i[`RB_WC_BIT]) && !sw_rst_i |=> st_r.wc;
  endproperty
  a_wc_keep: assert property (p_wc_keep) else $error("wc lost");

  property p_wr_any_clear;
    acc_wr_i && !write_any_clear_set_i |=> !st_r.write_any_clear;
  endproperty
  a_wr_any_clear: assert property (p_wr_any_clear) else $error("any-write flag kept");

  property p_wr_any_hold;
    st_r.write_any_clear && !acc_wr_i && !sw_rst_i |=> st_r.write_any_clear;
  endproperty
  a_wr_any_hold: assert property (p_wr_any_hold) else $error("any-write flag lost");

  property p_rc_read;
    acc_rd_i && !rc_set_i |=> !st_r.rc && acc_rdata_o[`RB_RC_BIT] == $past(st_r.rc);
  endproperty
  a_rc_read: assert property (p_rc_read) else $error("rc read wrong");

  property p_rc_hold;
    st_r.rc && !acc_rd_i && !sw_rst_i |=> st_r.rc;
  endproperty
  a_rc_hold: assert property (p_rc_hold) else $error("rc cleared without read");

  sequence s_latch_lo_low;
    !latch_low_cond_i && !sw_rst_i;
  endsequence
  sequence s_latch_lo_quiet;
    latch_low_cond_i && !acc_rd_i && !sw_rst_i;
  endsequence
  property p_latch_lo_latch;
    s_latch_lo_low ##1 s_latch_lo_quiet |=> !st_r.latch_low;
  endproperty
  a_latch_lo_latch: assert property (p_latch_lo_latch) else $error("latched low lost");

  property p_latch_lo_rearm;
    acc_rd_i && latch_low_cond_i && !sw_rst_i |=> st_r.latch_low;
  endproperty
  a_latch_lo_rearm: assert property (p_latch_lo_rearm) else $error("low latch not re-armed");

  property p_latch_hi_clear;
    acc_rd_i && !latch_high_set_i && !sw_rst_i |=> !st_r.latch_high;
  endproperty
  a_latch_hi_clear: assert property (p_latch_hi_clear) else $error("high latch kept on read");

  property p_latch_hi_hold;
    st_r.latch_high && !acc_rd_i && !sw_rst_i |=> st_r.latch_high;
  endproperty
  a_latch_hi_hold: assert property (p_latch_hi_hold) else $error("high latch lost");

  sequence s_self_clr_write;
    acc_wr_i && acc_wdata_i[`RB_SELF_CLR_BIT] && !sw_rst_i;
  endsequence
  sequence s_self_clr_pulse;
    self_clearing_o ##1 !self_clearing_o;
  endsequence
  property p_self_clr_pulse;
    s_self_clr_write ##1 !acc_wr_i |-> s_self_clr_pulse;
  endproperty
  a_self_clr_pulse: assert property (p_self_clr_pulse) else $error("bit not self-cleared");

  property p_self_clr_zero;
    acc_wr_i && !acc_wdata_i[`RB_SELF_CLR_BIT] |=> !self_clearing_o;
  endproperty
  a_self_clr_zero: assert property (p_self_clr_zero) else $error("zero write set the bit");

  sequence s_ss_write;
    acc_wr_i && !acc_wdata_i[`RB_SS_BIT] && !sw_rst_i;
  endsequence
  property p_ss_pulse;
    s_ss_write ##1 !acc_wr_i && !sw_rst_i |-> !ss_o ##1 ss_o;
  endproperty
  a_ss_pulse: assert property (p_ss_pulse) else $error("ss not self-set");

  property p_sticky_hold;
    st_r.sticky && !acc_rd_i && !sw_rst_i |=> st_r.sticky;
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky dropped");

  property p_sticky_follow;
    acc_rd_i && !sw_rst_i |=> st_r.sticky == $past(sticky_cond_i);
  endproperty
  a_sticky_follow: assert property (p_sticky_follow) else $error("sticky not following");

  property p_imm_keep;
    sw_rst_i && !acc_wr_i |=> imm_o == $past(imm_o) && rw_o == `RB_RW_RST;
  endproperty
  a_imm_keep: assert property (p_imm_keep) else $error("soft reset wrong");

  sequence s_rw_write;
    acc_wr_i && !sw_rst_i;
  endsequence
  // a software reset in the quiet cycles would rightly drop the bit
  sequence s_rw_quiet;
    (!acc_wr_i && !sw_rst_i) [*2];
  endsequence
  property p_rw_store;
    s_rw_write ##1 s_rw_quiet |=> rw_o == $past(acc_wdata_i[`RB_RW_BIT], 3);
  endproperty
  a_rw_store: assert property (p_rw_store) else $error("rw not held");

  property p_set_wins;
    write_any_clear_set_i && acc_wr_i && !sw_rst_i |=> st_r.write_any_clear;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

endmodule

// file: design/bit_cells_cfg.svh
`ifndef BIT_CELLS_CFG_SVH
`define BIT_CELLS_CFG_SVH
// What this block does
// - read-only bit returns hardware value; writes leave it unchanged.
// - write-only bit stores writes; its read data is undefined, do not check.
// - write-one-to-clear bit clears on written one; written zero does nothing.
// - write_any_clear bit clears on any write, whatever the data.
// - read-to-clear bit returns contents then clears; writes do nothing.
// - latch_low_clear_on_read holds a low condition until the register is read.
// - latch_high_clear_on_read holds a high event until the register is read.
// - self_clearing bit returns to zero by itself; writing zero does nothing.
// - self-setting bit returns to one by itself; writing one does nothing.
// - sticky_high_status stays set after its condition until software reads it.
// - after that read, it follows the condition: set if held, else zero.
// - soft_reset_immune bits keep state on software reset; others take defaults.
// - reserved positions give no guaranteed read value; nobody relies on them.
// - plain read-write bit stores the write and returns it on reads.

// ----------------------------------------------------------------
// register layout
// ----------------------------------------------------------------
`define RB_W          16
`define RB_RO_BIT     0
`define RB_WO_BIT     1
`define RB_WC_BIT     2
`define RB_WR_ANY_BIT   3
`define RB_RC_BIT       4
`define RB_LATCH_LO_BIT 5
`define RB_LATCH_HI_BIT 6
`define RB_SELF_CLR_BIT 7
`define RB_SS_BIT     8
`define RB_STICKY_BIT 9
`define RB_RW_BIT     10
`define RB_IMM_BIT    11

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RB_LATCH_LO_RST 1'h1
`define RB_SS_RST     1'h1
`define RB_RW_RST     1'h0
`define RB_IMM_RST    1'h0
`endif

// file: design/bit_cells_pkg.sv
package bit_cells_pkg;
  typedef struct packed {
    logic [15:0] rdata;
    logic        wo;
    logic        wc;
    logic        write_any_clear;
    logic        rc;
    logic        latch_low;
    logic        latch_high;
    logic        self_clearing;
    logic        ss;
    logic        sticky;
    logic        rw;
    logic        imm;
  } cells_state_t;
endpackage

// file: tb/register_bit_attribute_cells_test.sv
`timescale 1ns/1ps
`include "bit_cells_cfg.svh"
module register_bit_attribute_cells_test;
  logic        sys_clk_i;
  logic        rstn_i;
  logic        sw_rst_i;
  logic        acc_rd_i;
  logic        acc_wr_i;
  logic [15:0] acc_wdata_i;
  logic [15:0] acc_rdata_o;
  logic        ro_val_i;
  logic        latch_low_cond_i;
  logic [4:0]  ev;
  logic        wo_o;
  logic        self_clearing_o;
  logic        ss_o;
  logic        rw_o;
  logic        imm_o;
  logic [15:0] rdat;
  int          error_cnt;
  int          checked;

  register_bit_attribute_cells u_register_bit_attribute_cells (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sw_rst_i(sw_rst_i),
    .acc_rd_i(acc_rd_i), .acc_wr_i(acc_wr_i), .acc_wdata_i(acc_wdata_i),
    .acc_rdata_o(acc_rdata_o), .ro_val_i(ro_val_i), .wc_set_i(ev[0]),
    .write_any_clear_set_i(ev[1]), .rc_set_i(ev[2]), .latch_low_cond_i(latch_low_cond_i),
    .latch_high_set_i(ev[3]), .sticky_cond_i(ev[4]), .wo_o(wo_o),
    .self_clearing_o(self_clearing_o), .ss_o(ss_o), .rw_o(rw_o), .imm_o(imm_o)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    sys_clk_i = 1'h0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task chk(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // reserved bits 15:12 are always written as zero; the port carries no
  // address, so no reserved address is ever reached
  task wr(input logic [15:0] d);
    @(posedge sys_clk_i);
    acc_wr_i    <= 1'h1;
    acc_wdata_i <= d;
    @(posedge sys_clk_i);
    acc_wr_i <= 1'h0;
    #1;
  endtask

  // read data stands one cycle only, so it is caught right after the edge
  task rd;
    @(posedge sys_clk_i);
    acc_rd_i <= 1'h1;
    @(posedge sys_clk_i);
    acc_rd_i <= 1'h0;
    #1;
    rdat = acc_rdata_o;
  endtask

  task pulse(input int i);
    @(posedge sys_clk_i);
    ev[i] <= 1'h1;
    @(posedge sys_clk_i);
    ev[i] <= 1'h0;
  endtask

  task final_report;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_ro_rw;
    rd;
    chk(rdat[`RB_LATCH_LO_BIT], 1'h1);
    chk(rdat[`RB_SS_BIT], 1'h1);
    wr(16'h0400);
    chk(rw_o, 1'h1);
    chk(wo_o, 1'h0);
    rd;
    chk(rdat[`RB_RO_BIT], 1'h1);
    chk(rdat[`RB_RW_BIT], 1'h1);
    @(posedge sys_clk_i);
    ro_val_i <= 1'h0;
    rd;
    chk(rdat[`RB_RO_BIT], 1'h0);
    wr(16'h0003);
    chk(wo_o, 1'h1);
    chk(rw_o, 1'h0);
    rd;
    chk(rdat[`RB_RO_BIT], 1'h0);
    $display("read-only and read-write test done");
  endtask

  task t_clears;
    @(posedge sys_clk_i);
    ev[0]       <= 1'h1;
    acc_wr_i    <= 1'h1;
    acc_wdata_i <= 16'h0004;
    @(posedge sys_clk_i);
    ev[0]    <= 1'h0;
    acc_wr_i <= 1'h0;
    rd;
    chk(rdat[`RB_WC_BIT], 1'h1);
    wr(16'h0000);
    rd;
    chk(rdat[`RB_WC_BIT], 1'h1);
    wr(16'h0004);
    rd;
    chk(rdat[`RB_WC_BIT], 1'h0);
    pulse(1);
    rd;
    chk(rdat[`RB_WR_ANY_BIT], 1'h1);
    wr(16'h0000);
    rd;
    chk(rdat[`RB_WR_ANY_BIT], 1'h0);
    pulse(2);
    wr(16'h0010);
    rd;
    chk(rdat[`RB_RC_BIT], 1'h1);
    rd;
    chk(rdat[`RB_RC_BIT], 1'h0);
    $display("write and read clear test done");
  endtask

  task t_latches;
    @(posedge sys_clk_i);
    latch_low_cond_i <= 1'h0;
    pulse(3);
    latch_low_cond_i <= 1'h1;
    wr(16'h0000);
    rd;
    chk(rdat[`RB_LATCH_LO_BIT], 1'h0);
    chk(rdat[`RB_LATCH_HI_BIT], 1'h1);
    rd;
    chk(rdat[`RB_LATCH_LO_BIT], 1'h1);
    chk(rdat[`RB_LATCH_HI_BIT], 1'h0);
    pulse(4);
    rd;
    chk(rdat[`RB_STICKY_BIT], 1'h1);
    rd;
    chk(rdat[`RB_STICKY_BIT], 1'h0);
    @(posedge sys_clk_i);
    ev[4] <= 1'h1;
    rd;
    rd;
    chk(rdat[`RB_STICKY_BIT], 1'h1);
    @(posedge sys_clk_i);
    ev[4] <= 1'h0;
    $display("latch test done");
  endtask

  task t_self;
    wr(16'h0180);
    chk(self_clearing_o, 1'h1);
    chk(ss_o, 1'h1);
    @(posedge sys_clk_i);
    #1;
    chk(self_clearing_o, 1'h0);
    wr(16'h0000);
    chk(ss_o, 1'h0);
    chk(self_clearing_o, 1'h0);
    @(posedge sys_clk_i);
    #1;
    chk(ss_o, 1'h1);
    $display("self clear and set test done");
  endtask

  task t_soft_reset;
    wr(16'h0c00);
    @(posedge sys_clk_i);
    sw_rst_i <= 1'h1;
    @(posedge sys_clk_i);
    sw_rst_i <= 1'h0;
    #1;
    chk(imm_o, 1'h1);
    chk(rw_o, 1'h0);
    // a hardware reset does clear the immune bit
    @(posedge sys_clk_i);
    rstn_i <= 1'h0;
    @(posedge sys_clk_i);
    rstn_i <= 1'h1;
    #1;
    chk(imm_o, 1'h0);
    chk(ss_o, 1'h1);
    $display("soft reset test done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn_i, sw_rst_i, acc_rd_i, acc_wr_i, ev} = '0;
    acc_wdata_i = 16'h0000;
    ro_val_i    = 1'h1;
    latch_low_cond_i = 1'h1;
    error_cnt   = 0;
    checked     = 0;
    repeat (3) @(posedge sys_clk_i);
    rstn_i <= 1'h1;
    t_ro_rw;
    t_clears;
    t_latches;
    t_self;
    t_soft_reset;
    final_report;
  end

  // a hang is cut short well inside the cycle budget
  initial begin
    #100000;
    error_cnt++;
    final_report;
  end
endmodule
